// ==== hw/ultrasonic_distance_input.sv ====
// ultrasonic distance input: transducer drive, echo timing, filtering and register map
// Operation
// R01: temperature reported in tenths of a degree
// R02: distance in mm, lsb carries threshold status
// R03: alarms replace distance with reserved codes
// R04: sensor runs only while enable holds one
// R05: sample once per interval of time units
// R06: pulse transducer exactly drive-count cycles
// R07: reflection valid after receive-count echo cycles
// R08: full-scale mode maps span onto 0..65535
// R09: engineering mode keeps native units
// R10: maximum and minimum bound the input span
// R11: on at threshold, off below threshold minus hysteresis
// R12: report only changes of at least delta
// R13: debounce transitions by consecutive sample counts
// R14: push configured registers on change of state
// R15: median filter when median enable is one
// R16: tau filter off at 0, stronger to 6
// R17: teach sets threshold to distance minus window
// R18: invert selects status for below-threshold distance
// R19: boost register selects transducer power level
// R20: sensitivity 0 off, 0x8000 default, sides adjust
// R21: alarm counts as below or above threshold
// R22: push slots default to distance, temperature, threshold, window
// R23: interval counter restarts on enable or write
`timescale 1ns/1ps
module ultrasonic_distance_input #(
  parameter bit BAND_24GHZ = 1'b0,
  parameter int UNIT_CYCLES = (BAND_24GHZ ? ultrasonic_pkg::UNIT_MS_24GHZ
                                          : ultrasonic_pkg::UNIT_MS_SUBGHZ)
                              * (ultrasonic_pkg::CLK_HZ / ultrasonic_pkg::MS_PER_S)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register access from the radio
  input wire ultrasonic_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  // transducer
  output logic tx_drive,
  output logic tx_boost,
  input wire logic echo_in,
  // thermistor converter on this clock
  input wire logic [15:0] temp_tenths,
  input wire logic thermistor_fault,
  // push toward the master radio
  output ultrasonic_pkg::push_t push_out,
  output logic push_valid,
  input wire logic push_ready,
  // current threshold status
  output logic status_out
);
  import ultrasonic_pkg::*;

  typedef enum {ST_IDLE, ST_DRIVE, ST_LISTEN, ST_SCALE, ST_UPDATE} meas_state_t;
  typedef enum {AL_NONE, AL_NO_ECHO, AL_MISMATCH} alarm_t;

  // register lookup shared by reads and pushes
  function automatic logic [15:0] lookup(input logic [15:0] a, input logic [15:0] regs [NCFG],
                                         input logic [15:0] t, input logic [15:0] d);
    logic [15:0] v;
    v = '0;
    if (a == ADDR_TEMP) v = t;
    if (a == ADDR_DIST) v = d;
    for (int i = 0; i < NCFG; i++) begin
      if (a == CFG_ADDR[i] && i != C_TEACH) v = regs[i];
    end
    return v;
  endfunction

  // median of three samples
  function automatic logic [15:0] median3(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] c);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    hi = (hi < c) ? hi : c;
    return (lo > hi) ? lo : hi;
  endfunction

  logic [15:0] cfg_q [NCFG];
  logic [15:0] cfg_d [NCFG];
  logic [15:0] temp_q, temp_d;
  logic [15:0] dist_q, dist_d;
  logic [15:0] dist_val_q, dist_val_d;
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic intv_restart;
  logic [15:0] teach_thr;

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  assign teach_thr = (dist_val_q > cfg_q[C_WINDOW]) ? dist_val_q - cfg_q[C_WINDOW] : '0;

  // writes, teach and read answers
  always_comb begin
    cfg_d = cfg_q;
    intv_restart = 1'b0;
    ack_d = reg_req.valid;
    rdata_d = rdata_q;
    if (reg_req.valid && reg_req.write) begin
      for (int i = 0; i < NCFG; i++) begin
        if (reg_req.addr == CFG_ADDR[i]) cfg_d[i] = reg_req.wdata;
      end
      if (reg_req.addr == CFG_ADDR[C_INTERVAL]) intv_restart = 1'b1; // [R23]
      if (reg_req.addr == CFG_ADDR[C_TEACH] && reg_req.wdata == VAL_ON) begin
        cfg_d[C_THRESH] = teach_thr; // [R17]
      end
    end else if (reg_req.valid) begin
      rdata_d = lookup(reg_req.addr, cfg_q, temp_q, dist_q);
    end
    cfg_d[C_TEACH] = '0; // teach is a trigger and reads back zero
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= CFG_RST; // [R22]
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign tx_boost = (cfg_q[C_BOOST] == VAL_ON); // [R19]

  // ----------------------------------------------------------------------
  // echo synchroniser
  // ----------------------------------------------------------------------
  logic echo_s1_q, echo_s2_q, echo_s3_q;
  logic echo_rise;

  always_ff @(posedge clock) begin
    if (rst) begin
      echo_s1_q <= 1'b0;
      echo_s2_q <= 1'b0;
      echo_s3_q <= 1'b0;
    end else begin
      echo_s1_q <= echo_in;
      echo_s2_q <= echo_s1_q;
      echo_s3_q <= echo_s2_q;
    end
  end

  assign echo_rise = echo_s2_q & ~echo_s3_q;

  // ----------------------------------------------------------------------
  // sample interval timer
  // ----------------------------------------------------------------------
  logic en_on, en_was_q;
  logic [31:0] unit_cnt_q, unit_cnt_d;
  logic [15:0] intv_cnt_q, intv_cnt_d;
  logic sample_go;

  assign en_on = (cfg_q[C_ENABLE] == VAL_ON); // [R04]

  // time unit divider and interval count
  always_comb begin
    unit_cnt_d = unit_cnt_q + 32'h1;
    intv_cnt_d = intv_cnt_q;
    sample_go = 1'b0;
    if (!en_on || !en_was_q || intv_restart) begin
      unit_cnt_d = '0; // [R23]
      intv_cnt_d = '0;
    end else if (unit_cnt_q == 32'(UNIT_CYCLES - 1)) begin
      unit_cnt_d = '0;
      if (intv_cnt_q + 16'h1 >= cfg_q[C_INTERVAL]) begin
        intv_cnt_d = '0;
        sample_go = 1'b1; // [R05]
      end else begin
        intv_cnt_d = intv_cnt_q + 16'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      en_was_q <= 1'b0;
      unit_cnt_q <= '0;
      intv_cnt_q <= '0;
    end else begin
      en_was_q <= en_on;
      unit_cnt_q <= unit_cnt_d;
      intv_cnt_q <= intv_cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // measurement and filtering
  // ----------------------------------------------------------------------
  meas_state_t state_q, state_d;
  alarm_t alarm_q, alarm_d;
  logic drive_q, drive_d;
  logic [15:0] cyc_q, cyc_d;
  logic [15:0] pulses_q, pulses_d;
  logic [15:0] pre_q, pre_d;
  logic [15:0] mm_q, mm_d;
  logic [15:0] edges_q, edges_d;
  logic [15:0] echo_mm_q, echo_mm_d;
  logic [15:0] raw_q, raw_d;
  logic [31:0] num_q, num_d;
  logic [16:0] rem_q, rem_d;
  logic [5:0] step_q, step_d;
  logic [15:0] h1_q, h1_d, h2_q, h2_d;
  logic [15:0] filt_q, filt_d;
  logic filt_ok_q, filt_ok_d;
  logic on_q, on_d;
  logic [7:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
  logic status_q, status_d;
  logic changed;
  logic [15:0] rx_need, span, clamped, diff, med, filt, off_pt, dev, lvl;
  logic [16:0] rem_t;
  logic [16:0] tau_step;
  logic cand_on;

  // sensitivity nudges the echo count needed for a reflection
  always_comb begin
    rx_need = (cfg_q[C_RECV] == '0) ? 16'h1 : cfg_q[C_RECV];
    if (cfg_q[C_SENS] != SENS_OFF && cfg_q[C_SENS] < SENS_DEFAULT && rx_need > 16'h1) begin
      rx_need = rx_need - 16'h1; // [R20]
    end else if (cfg_q[C_SENS] > SENS_DEFAULT) begin
      rx_need = rx_need + 16'h1; // [R20]
    end
  end

  // span clamp and offset for full-scale division
  assign span = (cfg_q[C_MAX] > cfg_q[C_MIN]) ? cfg_q[C_MAX] - cfg_q[C_MIN] : '0;
  assign clamped = (echo_mm_d > cfg_q[C_MAX]) ? cfg_q[C_MAX] :
                   (echo_mm_d < cfg_q[C_MIN]) ? cfg_q[C_MIN] : echo_mm_d; // [R10]
  assign diff = clamped - cfg_q[C_MIN];
  assign rem_t = {rem_q[15:0], num_q[31]};

  // filter chain and threshold decision on the finished sample
  always_comb begin
    med = (cfg_q[C_MEDIAN] == VAL_ON) ? median3(raw_q, h1_q, h2_q) : raw_q; // [R15]
    lvl = (cfg_q[C_LOWPASS] > LOWPASS_STRONGEST_LEVEL) ? LOWPASS_STRONGEST_LEVEL
                                                       : cfg_q[C_LOWPASS];
    tau_step = 17'($signed({1'b0, med}) - $signed({1'b0, filt_q}));
    tau_step = 17'($signed(tau_step) >>> lvl[2:0]);
    if (lvl == LOWPASS_OFF_LEVEL || !filt_ok_q) begin
      filt = med; // [R16]
    end else begin
      filt = 16'(filt_q + tau_step[15:0]); // [R16]
    end
    off_pt = (cfg_q[C_THRESH] > cfg_q[C_HYST]) ? cfg_q[C_THRESH] - cfg_q[C_HYST] : '0;
    dev = (filt > dist_val_q) ? filt - dist_val_q : dist_val_q - filt;
    if (thermistor_fault || alarm_q != AL_NONE) begin
      cand_on = (cfg_q[C_ALARM_LOW] == '0); // [R21]
    end else if (filt >= cfg_q[C_THRESH]) begin
      cand_on = 1'b1; // [R11]
    end else if (filt < off_pt) begin
      cand_on = 1'b0; // [R11]
    end else begin
      cand_on = on_q;
    end
  end

  // measurement sequence
  always_comb begin
    state_d = state_q;
    alarm_d = alarm_q;
    drive_d = 1'b0;
    cyc_d = '0;
    pulses_d = pulses_q;
    pre_d = '0;
    mm_d = mm_q;
    edges_d = edges_q;
    echo_mm_d = echo_mm_q;
    raw_d = raw_q;
    num_d = num_q;
    rem_d = rem_q;
    step_d = step_q;
    h1_d = h1_q;
    h2_d = h2_q;
    filt_d = filt_q;
    filt_ok_d = filt_ok_q;
    on_d = on_q;
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    status_d = status_q;
    dist_d = dist_q;
    dist_val_d = dist_val_q;
    temp_d = temp_q;
    case (state_q)
      ST_IDLE: begin
        pulses_d = '0;
        mm_d = '0;
        edges_d = '0;
        alarm_d = AL_NONE;
        if (sample_go) begin
          state_d = (cfg_q[C_DRIVE] == '0) ? ST_LISTEN : ST_DRIVE;
          drive_d = (cfg_q[C_DRIVE] != '0);
        end
      end
      ST_DRIVE: begin
        drive_d = drive_q;
        cyc_d = cyc_q + 16'h1;
        if (cyc_q == 16'(DRIVE_HALF_CYCLES - 1)) begin
          cyc_d = '0;
          drive_d = ~drive_q;
          if (drive_q) begin
            pulses_d = pulses_q + 16'h1;
            if (pulses_q + 16'h1 >= cfg_q[C_DRIVE]) begin
              state_d = ST_LISTEN; // [R06]
            end
          end
        end
      end
      ST_LISTEN: begin
        pre_d = pre_q + 16'h1;
        if (pre_q == 16'(CYCLES_PER_MM - 1)) begin
          pre_d = '0;
          mm_d = mm_q + 16'h1;
        end
        if (echo_rise) begin
          edges_d = edges_q + 16'h1;
          if (edges_q == '0) echo_mm_d = mm_q;
          if (edges_q + 16'h1 >= rx_need) begin
            raw_d = clamped; // [R07] [R09]
            num_d = {diff, 16'h0} - {16'h0, diff};
            rem_d = '0;
            step_d = '0;
            state_d = (cfg_q[C_FULLSCALE] == VAL_ON) ? ST_SCALE : ST_UPDATE; // [R08]
            if (cfg_q[C_FULLSCALE] == VAL_ON && span == '0) begin
              raw_d = '0;
              state_d = ST_UPDATE;
            end
          end
        end else if (mm_q >= 16'(MAX_RANGE_MM)) begin
          alarm_d = (edges_q == '0) ? AL_NO_ECHO : AL_MISMATCH; // [R03]
          state_d = ST_UPDATE;
        end
      end
      ST_SCALE: begin
        // restoring division of the offset times 65535 by the span
        if (rem_t >= {1'b0, span}) begin
          rem_d = rem_t - {1'b0, span};
          num_d = {num_q[30:0], 1'b1};
        end else begin
          rem_d = rem_t;
          num_d = {num_q[30:0], 1'b0};
        end
        step_d = step_q + 6'h1;
        if (step_q == 6'(DIV_STEPS - 1)) begin
          raw_d = (num_d[31:16] != '0) ? 16'hffff : num_d[15:0]; // [R08]
          state_d = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        state_d = ST_IDLE;
        temp_d = temp_tenths; // [R01]
        // consecutive-sample debounce
        if (cand_on) begin
          lo_cnt_d = '0;
          hi_cnt_d = (hi_cnt_q == 8'hff) ? hi_cnt_q : hi_cnt_q + 8'h1;
          if (cfg_q[C_HIGH_CNT][7:0] == '0 || hi_cnt_q + 8'h1 >= cfg_q[C_HIGH_CNT][7:0]) begin
            on_d = 1'b1; // [R13]
          end
        end else begin
          hi_cnt_d = '0;
          lo_cnt_d = (lo_cnt_q == 8'hff) ? lo_cnt_q : lo_cnt_q + 8'h1;
          if (cfg_q[C_LOW_CNT][7:0] == '0 || lo_cnt_q + 8'h1 >= cfg_q[C_LOW_CNT][7:0]) begin
            on_d = 1'b0; // [R13]
          end
        end
        status_d = on_d ^ (cfg_q[C_INVERT] == VAL_ON); // [R18]
        if (thermistor_fault) begin
          dist_d = {CODE_THERMISTOR[15:1], status_d}; // [R03]
        end else if (alarm_q == AL_NO_ECHO) begin
          dist_d = {CODE_NO_ECHO[15:1], status_d}; // [R03]
        end else if (alarm_q == AL_MISMATCH) begin
          dist_d = {CODE_MISMATCH[15:1], status_d}; // [R03]
        end else begin
          h2_d = h1_q;
          h1_d = raw_q;
          filt_d = filt;
          filt_ok_d = 1'b1;
          if (cfg_q[C_DELTA] == '0 || dev >= cfg_q[C_DELTA]) begin
            dist_val_d = filt; // [R12]
          end
          dist_d = {dist_val_d[15:1], status_d}; // [R02]
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!en_on) begin
      state_d = ST_IDLE; // [R04]
      drive_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      alarm_q <= AL_NONE;
      drive_q <= 1'b0;
      cyc_q <= '0;
      pulses_q <= '0;
      pre_q <= '0;
      mm_q <= '0;
      edges_q <= '0;
      echo_mm_q <= '0;
      raw_q <= '0;
      num_q <= '0;
      rem_q <= '0;
      step_q <= '0;
      h1_q <= '0;
      h2_q <= '0;
      filt_q <= '0;
      filt_ok_q <= 1'b0;
      on_q <= 1'b0;
      hi_cnt_q <= '0;
      lo_cnt_q <= '0;
      status_q <= 1'b0;
      dist_q <= '0;
      dist_val_q <= '0;
      temp_q <= '0;
    end else begin
      state_q <= state_d;
      alarm_q <= alarm_d;
      drive_q <= drive_d;
      cyc_q <= cyc_d;
      pulses_q <= pulses_d;
      pre_q <= pre_d;
      mm_q <= mm_d;
      edges_q <= edges_d;
      echo_mm_q <= echo_mm_d;
      raw_q <= raw_d;
      num_q <= num_d;
      rem_q <= rem_d;
      step_q <= step_d;
      h1_q <= h1_d;
      h2_q <= h2_d;
      filt_q <= filt_d;
      filt_ok_q <= filt_ok_d;
      on_q <= on_d;
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      status_q <= status_d;
      dist_q <= dist_d;
      dist_val_q <= dist_val_d;
      temp_q <= temp_d;
    end
  end

  assign tx_drive = drive_q;
  assign status_out = status_q;
  assign changed = (state_q == ST_UPDATE) && (status_d != status_q);

  // ----------------------------------------------------------------------
  // change-of-state push sequencer
  // ----------------------------------------------------------------------
  logic push_busy_q, push_busy_d;
  logic [2:0] push_idx_q, push_idx_d;
  logic [15:0] slot_addr;

  assign slot_addr = cfg_q[C_PUSH1 + int'(push_idx_q[1:0])];
  assign push_valid = push_busy_q && (slot_addr != '0);
  assign push_out.addr = slot_addr;
  assign push_out.data = lookup(slot_addr, cfg_q, temp_q, dist_q);

  // walk the four slots, skipping empty ones
  always_comb begin
    push_busy_d = push_busy_q;
    push_idx_d = push_idx_q;
    if (changed && cfg_q[C_PUSH_EN] == VAL_ON) begin
      push_busy_d = 1'b1; // [R14]
      push_idx_d = '0;
    end else if (push_busy_q && (slot_addr == '0 || push_ready)) begin
      push_idx_d = push_idx_q + 3'h1;
      if (push_idx_q == 3'(NPUSH - 1)) push_busy_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      push_busy_q <= 1'b0;
      push_idx_q <= '0;
    end else begin
      push_busy_q <= push_busy_d;
      push_idx_q <= push_idx_d;
    end
  end
endmodule

// ==== pkg/ultrasonic_pkg.sv ====
// constants, register map and carrier types for the ultrasonic distance input
package ultrasonic_pkg;
  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int UNIT_MS_SUBGHZ = 40;
  localparam int UNIT_MS_24GHZ = 20;
  localparam int SOUND_MM_PER_S = 343_000;
  localparam int CYCLES_PER_MM = (2 * CLK_HZ) / SOUND_MM_PER_S; // round trip, rounded down
  localparam int DRIVE_HZ = 40_000;
  localparam int DRIVE_HALF_CYCLES = CLK_HZ / (2 * DRIVE_HZ);
  localparam int MAX_RANGE_MM = 10_000;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_TEMP = 16'h0001;
  localparam logic [15:0] ADDR_DIST = 16'h0002;
  localparam int NCFG = 25;
  localparam int C_ENABLE = 0;
  localparam int C_INTERVAL = 1;
  localparam int C_DRIVE = 2;
  localparam int C_RECV = 3;
  localparam int C_MAX = 4;
  localparam int C_MIN = 5;
  localparam int C_FULLSCALE = 6;
  localparam int C_THRESH = 7;
  localparam int C_HYST = 8;
  localparam int C_DELTA = 9;
  localparam int C_HIGH_CNT = 10;
  localparam int C_LOW_CNT = 11;
  localparam int C_PUSH_EN = 12;
  localparam int C_MEDIAN = 13;
  localparam int C_LOWPASS = 14;
  localparam int C_WINDOW = 15;
  localparam int C_TEACH = 16;
  localparam int C_INVERT = 17;
  localparam int C_BOOST = 18;
  localparam int C_SENS = 19;
  localparam int C_ALARM_LOW = 20;
  localparam int C_PUSH1 = 21;
  localparam int NPUSH = 4;
  localparam logic [15:0] CFG_ADDR [NCFG] = '{
    16'h041b, 16'h041d, 16'h12c1, 16'h12c8, 16'h12ca, 16'h12cb, 16'h12cc, 16'h12cd,
    16'h12ce, 16'h12cf, 16'h12d0, 16'h12d1, 16'h12d2, 16'h12d3, 16'h12d4, 16'h12d7,
    16'h12d9, 16'h12da, 16'h12db, 16'h12dc, 16'h12df, 16'h1ee5, 16'h1ee6, 16'h1ee7,
    16'h1ee8};
  localparam logic [15:0] CFG_RST [NCFG] = '{
    16'h0000, 16'h0019, 16'h0008, 16'h0002, 16'h1388, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0002, 16'h0001, 16'h12cd,
    16'h12d7};
  // ----------------------------------------------------------------------
  // values and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] VAL_ON = 16'h0001;
  localparam logic [15:0] SENS_OFF = 16'h0000;
  localparam logic [15:0] SENS_DEFAULT = 16'h8000;
  localparam logic [15:0] LOWPASS_OFF_LEVEL = 16'h0000;
  localparam logic [15:0] LOWPASS_STRONGEST_LEVEL = 16'h0006;
  localparam logic [15:0] CODE_NO_ECHO = 16'hfffe;
  localparam logic [15:0] CODE_MISMATCH = 16'hfffc;
  localparam logic [15:0] CODE_THERMISTOR = 16'hfffa;
  localparam int DIV_STEPS = 32;
  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } push_t;
endpackage

// ==== verification/ultrasonic_distance_input_assertions.sv ====
// concurrent checks on the ultrasonic distance input ports
`timescale 1ns/1ps
module ultrasonic_distance_input_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire ultrasonic_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  // transducer
  input wire logic tx_drive,
  input wire logic tx_boost,
  // push and status
  input wire ultrasonic_pkg::push_t push_out,
  input wire logic push_valid,
  input wire logic push_ready,
  input wire logic status_out
);
  import ultrasonic_pkg::*;
  logic en_q, en_d, one_w, en_wr;
  int hi_q, hi_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // shadow of the enable register and length of the current drive high
  assign one_w = reg_req.wdata == 16'h0001;
  assign en_wr = reg_req.valid && reg_req.write && reg_req.addr == 16'h041b;
  always_comb begin
    en_d = en_wr ? one_w : en_q;
    hi_d = tx_drive ? hi_q + 1 : 0;
  end
  always_ff @(posedge clock) begin
    en_q <= rst ? 1'b0 : en_d;
    hi_q <= rst ? 0 : hi_d;
  end
  a_stop_on_disable: assert property (en_wr && !one_w |-> ##2 !tx_drive [*4])
    else $error("drive after disable");
  a_idle_no_drive: assert property (!en_q [*3] |-> !tx_drive)
    else $error("drive while disabled");
  a_drive_half_width: assert property ($fell(tx_drive) && en_q |-> hi_q == DRIVE_HALF_CYCLES)
    else $error("drive half period wrong");
  a_boost_follows: assert property (en_wr === 1'b0 && reg_req.valid && reg_req.write
    && reg_req.addr == 16'h12db |-> ##2 tx_boost == $past(one_w, 2))
    else $error("boost level wrong");
  a_teach_reads_zero: assert property (reg_req.valid && !reg_req.write
    && reg_req.addr == 16'h12d9 |=> reg_rdata == 16'h0000)
    else $error("teach read not zero");
  a_push_holds: assert property (push_valid && !push_ready
    |=> push_valid && $stable(push_out))
    else $error("push dropped before ready");
  a_push_slot_order: assert property (push_valid && push_ready && push_out.addr == 16'h0002
    |=> push_valid && push_out.addr == 16'h0001)
    else $error("push slot order wrong");
  a_status_in_lsb: assert property (push_valid && push_out.addr == ADDR_DIST
    |-> push_out.data[0] == status_out)
    else $error("distance lsb not status");
endmodule

// ==== verification/echo_target_model.sv ====
// transducer echo source and slow master radio for the distance input bench
`timescale 1ns/1ps
module echo_target_model #(
  // echo half a millimetre past the fourth count of the design's round-trip timer
  parameter int DELAY = 4 * ultrasonic_pkg::CYCLES_PER_MM + ultrasonic_pkg::CYCLES_PER_MM / 2,
  parameter int PULSES = 2
) (
  // clock
  input wire logic clock,
  // transducer side
  input wire logic tx_drive,
  output logic echo_in,
  // master radio side
  output logic push_ready
);
  int cnt = -1;
  logic drv_q = 1'b0;
  // receiver output idles low; master starts not ready
  initial begin
    echo_in = 1'b0;
    push_ready = 1'b0;
  end
  // count from each drive fall, then ring the echo; master accepts every other cycle
  always @(negedge clock) begin
    drv_q <= tx_drive;
    cnt <= (drv_q && !tx_drive) ? 0 : (cnt < 0 ? cnt : cnt + 1);
    echo_in <= cnt >= DELAY && cnt < DELAY + 16 * PULSES && (cnt - DELAY) % 16 < 8;
    push_ready <= ~push_ready;
  end
endmodule

// ==== verification/ultrasonic_distance_input_tb_top.sv ====
// self-checking bench for the ultrasonic distance input
`timescale 1ns/1ps
module ultrasonic_distance_input_tb_top;
  import ultrasonic_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [15:0] reg_rdata, v, w;
  logic reg_ack, tx_drive, tx_boost, echo_in, push_valid, push_ready, status_out;
  logic [15:0] temp_tenths = 16'h00fa;
  logic thermistor_fault = 1'b0;
  push_t push_out;
  push_t got[$];
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  // 125 MHz clock
  always #4 clock = ~clock;
  // design with a 20-cycle time unit, and its far side
  ultrasonic_distance_input #(.UNIT_CYCLES(20)) ultrasonic_distance_input_i (.*);
  echo_target_model echo_target_model_i (.*);
  // log accepted pushes and cut a hung run short
  always @(posedge clock) begin
    if (push_valid && push_ready)
      got.push_back(push_out);
    cyc++;
    if (cyc == 90000)
      end_sim(1);
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write, strobe high for a single edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_req = '{1'b1, 1'b1, a, d};
    @(negedge clock);
    reg_req.valid = 1'b0;
  endtask
  // one read, data taken once the answer has landed
  task automatic rd(input logic [15:0] a, output logic [15:0] r);
    @(negedge clock);
    reg_req = '{1'b1, 1'b0, a, 16'h0000};
    @(negedge clock);
    chk(16'(reg_ack), 16'h0001);
    reg_req.valid = 1'b0;
    @(negedge clock);
    r = reg_rdata;
  endtask
  // re-read the distance until it leaves a known value
  task automatic poll(input logic [15:0] old);
    v = old;
    for (int i = 0; i < 400 && v === old; i++) begin
      repeat (40) @(negedge clock);
      rd(ADDR_DIST, v);
    end
  endtask
  // reset values, read-back, unmapped and read-only places
  task automatic t_regs;
    for (int i = 0; i < NCFG; i++) begin
      rd(CFG_ADDR[i], v);
      chk(v, CFG_RST[i]);
    end
    wr(16'h12db, 16'h0001);
    rd(16'h12db, v);
    chk({v[14:0], tx_boost}, 16'h0003);
    rd(16'h0003, v);
    chk(v, 16'h0000);
    rd(ADDR_DIST, w);
    wr(ADDR_DIST, 16'hffff);
    rd(ADDR_DIST, v);
    chk(v, w);
  endtask
  // first measurement sets the status and pushes all four slots
  task automatic t_first;
    wr(16'h041d, 16'h0001);
    wr(16'h12c1, 16'h0001);
    wr(16'h12d2, 16'h0001);
    wr(16'h041b, 16'h0001);
    poll(w);
    chk(v, 16'h0005);
    rd(ADDR_TEMP, v);
    chk(v, 16'h00fa);
    for (int i = 0; i < 200 && got.size() < 4; i++)
      @(negedge clock);
    chk(16'(got.size()), 16'h0004);
    for (int i = 0; i < 4; i++)
      chk(got[i].addr, CFG_RST[C_PUSH1 + i]);
    chk(got[0].data, 16'h0005);
    chk(got[1].data, 16'h00fa);
  endtask
  // teach moves the threshold to distance minus window
  task automatic t_teach;
    wr(16'h12d7, 16'h0001);
    wr(16'h12d9, 16'h0001);
    rd(16'h12cd, v);
    chk(v, 16'h0003);
  endtask
  // thermistor alarm code, hysteresis, alarm polarity and inversion
  task automatic t_alarm;
    thermistor_fault = 1'b1;
    poll(16'h0005);
    chk(v, 16'hfffb);
    wr(16'h12cd, 16'h0005);
    wr(16'h12ce, 16'h0002);
    thermistor_fault = 1'b0;
    poll(16'hfffb);
    chk(v, 16'h0005);
    wr(16'h12df, 16'h0001);
    thermistor_fault = 1'b1;
    poll(16'h0005);
    chk(v, 16'hfffa);
    wr(16'h12da, 16'h0001);
    thermistor_fault = 1'b0;
    poll(16'hfffa);
    chk(v, 16'h0005);
  endtask
  // full-scale maps 4 mm of a 0..8 span onto 0x7fff, status now low
  task automatic t_scale;
    wr(16'h12ca, 16'h0008);
    wr(16'h12cc, 16'h0001);
    poll(16'h0005);
    chk(v, 16'h7ffe);
    wr(16'h041b, 16'h0000);
  endtask
  // counts and verdict
  task automatic end_sim(input int f);
    n_fail += f;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_first();
    t_teach();
    t_alarm();
    t_scale();
    repeat (20) @(negedge clock);
    end_sim(0);
  end
endmodule
bind ultrasonic_distance_input ultrasonic_distance_input_assertions chk_i (.*);
